// File: pkg/apc_regs.svh
// Constants of the absolute position control block
`ifndef APC_REGS_SVH
`define APC_REGS_SVH
`define APC_POS_W       32
`define APC_SEL_W       3
`define APC_NUM_POS     8
`define APC_SET_W       8
`define APC_RST_KEEP    8'h03
`define APC_POS_ZERO    32'h0000_0000
`define APC_CLK_NS      25
`define APC_MS_NS       1000000
`define APC_TICKS_MS    (`APC_MS_NS / `APC_CLK_NS)
`define APC_DLY_W       8
`define APC_TICK_W      20
`define APC_PIN_W       14
`define APC_PIN_FW      0
`define APC_PIN_RV      1
`define APC_PIN_SEL     2
`define APC_PIN_POSITION_CLEAR_INPUT    5
`define APC_PIN_RKEY    6
`define APC_PIN_SPD     7
`define APC_PIN_UP      8
`define APC_PIN_DN      9
`define APC_PIN_TRQ     10
`define APC_PIN_PLS     11
`define APC_PIN_TCH     12
`define APC_PIN_HOME    13
`endif

// File: pkg/apc_pkg.sv
// Types of the absolute position control block
`include "apc_regs.svh"
package apc_pkg;
   // Eight stored target positions, entry 0 in the low word
   typedef struct packed {
      logic [`APC_NUM_POS-1:0][`APC_POS_W-1:0] pos;
   } apc_table_t;
   // Terminal functions after mode gating
   typedef struct packed {
      logic torque_en;   // Torque control may be entered
      logic pulse_en;    // Pulse-train position control allowed
      logic home_en;     // Home search allowed
      logic teach_en;    // Teach input active
      logic abs_ramp;    // Absolute-position speed and ramp set in use
   } apc_mode_t;
   // Control states
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SPEED,
      ST_MOVE,
      ST_LOCK
   } apc_state_t;
endpackage

// File: hw/apc_settle.sv
// Settling filter for the three position select inputs
`timescale 1ns/1ps
`include "apc_regs.svh"
module apc_settle #(
   parameter int TICKS_PER_MS = `APC_TICKS_MS  // Clock cycles in 1 ms
) (
   input  wire logic                  clk_in,     // System clock
   input  wire logic                  rst_n_in,   // Synchronised reset
   input  wire logic [`APC_SEL_W-1:0] code_in,    // Synchronised code
   input  wire logic [`APC_DLY_W-1:0] delay_in,   // Settle delay in ms
   output logic      [`APC_SEL_W-1:0] code_out    // Accepted code
);
   import apc_pkg::*;

   logic [`APC_SEL_W-1:0]  cand_ff, nxt_cand;   // Code being watched
   logic [`APC_SEL_W-1:0]  acc_ff, nxt_acc;     // Accepted code
   logic [`APC_TICK_W-1:0] tick_ff, nxt_tick;   // Cycles within a ms
   logic [`APC_DLY_W-1:0]  ms_ff, nxt_ms;       // Whole ms stable

   // Restart the wait on any change, accept once stable long enough
   always_comb begin
      nxt_cand = code_in;
      nxt_acc  = acc_ff;
      nxt_tick = tick_ff;
      nxt_ms   = ms_ff;
      if (code_in != cand_ff) begin
         nxt_tick = '0;
         nxt_ms   = '0;
      end else if (ms_ff >= delay_in) begin
         nxt_acc = cand_ff;    // R13
      end else if (tick_ff == TICKS_PER_MS[`APC_TICK_W-1:0] - 1'b1) begin
         nxt_tick = '0;
         nxt_ms   = ms_ff + 1'b1;
      end else begin
         nxt_tick = tick_ff + 1'b1;
      end
   end

   // Register the filter state
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cand_ff <= '0;
         acc_ff  <= '0;
         tick_ff <= '0;
         ms_ff   <= '0;
      end else begin
         cand_ff <= nxt_cand;
         acc_ff  <= nxt_acc;
         tick_ff <= nxt_tick;
         ms_ff   <= nxt_ms;
      end
   end

   assign code_out = acc_ff;

   // Accepted code only moves to a code that stood still the whole wait
   a_settle_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (acc_ff != $past(acc_ff)) |-> ($past(cand_ff) == acc_ff)
         && ($past(ms_ff) >= $past(delay_in)))  // R13
      else $error("Select code accepted before settling");
endmodule

// File: hw/apc_top.sv
// Absolute position control: target select, direction, counter, modes
// Operation
// [R01] Run to target, then servo-lock while run
// [R02] Run command direction ignored, run/stop only
// [R03] Forward if target minus current positive
// [R04] Power-up position is origin zero
// [R05] Zero target completes without moving
// [R06] Reset clears counter unless setting is 03
// [R07] Position clear zeroes counter and deviation
// [R08] Torque select ignored in this mode
// [R09] Pulse-train enable ignored in this mode
// [R10] Home search off, input becomes teach
// [R11] Three select bits index eight positions
// [R12] No select terminals: use position zero
// [R13] Select code accepted after settle delay
// [R14] Use absolute speed/ramp set, early decel
// [R15] Speed switch on selects speed control
// [R16] Counter held zero during speed control
// [R17] Zero target at switch: stop there
// [R18] Speed control direction from run command
// [R19] Homing completion clears position counter
// [R20] Signed counter tracks feedback both ways
`timescale 1ns/1ps
`include "apc_regs.svh"
module apc_top #(
   parameter int TICKS_PER_MS = `APC_TICKS_MS  // Clock cycles in 1 ms
) (
   input  wire logic                  clk_in,         // 40 MHz clock
   input  wire logic                  reset_n_in,     // Async reset, low
   input  wire logic                  abs_mode_in,    // Absolute mode on
   input  wire logic                  run_forward_cmd_in, // Pin: fwd run
   input  wire logic                  run_reverse_cmd_in, // Pin: rev run
   input  wire logic                  pos_select_bit0_in, // Pin: select 0
   input  wire logic                  pos_select_bit1_in, // Pin: select 1
   input  wire logic                  pos_select_bit2_in, // Pin: select 2
   input  wire logic                  select_assigned_in, // Select on
   input  wire apc_pkg::apc_table_t   stored_pos_in,  // Stored targets
   input  wire logic [`APC_DLY_W-1:0] select_settle_delay_in, // ms
   input  wire logic                  position_clear_input_in, // Pin
   input  wire logic                  position_clear_input_assigned_in,   // Clear on
   input  wire logic                  reset_key_in,       // Pin: reset
   input  wire logic [`APC_SET_W-1:0] reset_behaviour_setting_in, // Code
   input  wire logic                  speed_position_switch_in, // Pin
   input  wire logic                  fb_up_in,       // Pin: step fwd
   input  wire logic                  fb_down_in,     // Pin: step rev
   input  wire logic                  torque_control_select_in, // Pin
   input  wire logic                  pulse_train_enable_in, // Pin
   input  wire logic                  teach_input_in,     // Pin: teach
   input  wire logic                  homing_done_in, // Pin: homed
   input  wire logic [`APC_POS_W-1:0] decel_dist_in,  // Decel distance
   output logic                       motor_run_out,  // Drive motor
   output logic                       motor_fwd_out,  // 1 fwd, 0 rev
   output logic                       servo_lock_out, // Holding target
   output logic                       pos_complete_out, // Positioned
   output logic                       speed_ctrl_out, // Speed control
   output logic                       near_target_out, // Decelerate
   output logic signed [`APC_POS_W-1:0] current_pos_out, // Counter
   output logic signed [`APC_POS_W-1:0] deviation_out, // Deviation
   output logic signed [`APC_POS_W-1:0] target_pos_out, // Target
   output apc_pkg::apc_mode_t         mode_out        // Gated functions
);
   import apc_pkg::*;

   logic                       rst_a_ff, rst_b_ff;   // Reset release
   logic [`APC_PIN_W-1:0]      pin_raw;              // Raw pins
   logic [`APC_PIN_W-1:0]      pin_a_ff;             // First stage
   logic [`APC_PIN_W-1:0]      pin_b_ff;             // Second stage
   logic [`APC_PIN_W-1:0]      pin_c_ff;             // Edge history
   logic                       run_req;              // Run or stop
   logic                       fw_s, spd_s, position_clear_input_s, rkey_s; // Synced
   logic                       step_up, step_dn;     // Feedback steps
   logic [`APC_SEL_W-1:0]      sel_settled;          // Filtered code
   logic [`APC_SEL_W-1:0]      sel_idx;              // Table index
   logic signed [`APC_POS_W-1:0] target;             // Selected target
   logic signed [`APC_POS_W-1:0] diff;               // Target - current
   logic signed [`APC_POS_W-1:0] pos_ff, nxt_pos;    // Position counter
   logic signed [`APC_POS_W-1:0] dev_ff, nxt_dev;    // Deviation
   logic                       clr_position_clear_input, clr_rkey;   // Clear causes
   apc_state_t                 st_ff, nxt_st;        // Control state
   logic                       run_ff, nxt_run;      // Motor run
   logic                       fwd_ff, nxt_fwd;      // Direction
   logic                       lock_ff, nxt_lock;    // Servo lock
   logic                       done_ff, nxt_done;    // Complete
   logic                       near_ff, nxt_near;    // Near target
   apc_mode_t                  mode_ff, nxt_mode;    // Gated functions

   // Reset release through two flip-flops
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rst_a_ff <= 1'b0;
         rst_b_ff <= 1'b0;
      end else begin
         rst_a_ff <= 1'b1;
         rst_b_ff <= rst_a_ff;
      end
   end

   // Gather the pin inputs into one vector
   assign pin_raw = {homing_done_in, teach_input_in,
                     pulse_train_enable_in, torque_control_select_in,
                     fb_down_in, fb_up_in, speed_position_switch_in,
                     reset_key_in, position_clear_input_in,
                     pos_select_bit2_in, pos_select_bit1_in,
                     pos_select_bit0_in, run_reverse_cmd_in,
                     run_forward_cmd_in};

   // Two-stage synchroniser per pin, plus one stage for edges
   genvar gi;
   generate
      for (gi = 0; gi < `APC_PIN_W; gi++) begin : g_sync
         always_ff @(posedge clk_in or negedge rst_b_ff) begin
            if (!rst_b_ff) begin
               pin_a_ff[gi] <= 1'b0;
               pin_b_ff[gi] <= 1'b0;
               pin_c_ff[gi] <= 1'b0;
            end else begin
               pin_a_ff[gi] <= pin_raw[gi];
               pin_b_ff[gi] <= pin_a_ff[gi];
               pin_c_ff[gi] <= pin_b_ff[gi];
            end
         end
      end
   endgenerate

   // Synchronised levels and feedback step edges
   assign fw_s    = pin_b_ff[`APC_PIN_FW];
   assign run_req = pin_b_ff[`APC_PIN_FW] | pin_b_ff[`APC_PIN_RV]; // R02
   assign spd_s   = pin_b_ff[`APC_PIN_SPD];
   assign position_clear_input_s  = pin_b_ff[`APC_PIN_POSITION_CLEAR_INPUT];
   assign rkey_s  = pin_b_ff[`APC_PIN_RKEY];
   assign step_up = pin_b_ff[`APC_PIN_UP] & ~pin_c_ff[`APC_PIN_UP];
   assign step_dn = pin_b_ff[`APC_PIN_DN] & ~pin_c_ff[`APC_PIN_DN];

   // Select inputs wait out the settle delay
   apc_settle #(
      .TICKS_PER_MS (TICKS_PER_MS)
   ) u_settle (
      .clk_in   (clk_in),
      .rst_n_in (rst_b_ff),
      .code_in  (pin_b_ff[`APC_PIN_SEL +: `APC_SEL_W]),
      .delay_in (select_settle_delay_in),
      .code_out (sel_settled)
   );

   // Binary index, first select input least significant
   assign sel_idx = select_assigned_in ? sel_settled : '0;  // R11 R12
   assign target  = stored_pos_in.pos[sel_idx];               // R11
   assign diff    = target - pos_ff;

   // Clear causes for the position counter
   assign clr_position_clear_input = position_clear_input_assigned_in & position_clear_input_s;               // R07
   assign clr_rkey = rkey_s &
      (reset_behaviour_setting_in != `APC_RST_KEEP);          // R06

   // Position counter and deviation next values
   always_comb begin
      nxt_pos = pos_ff;
      nxt_dev = dev_ff;
      if (clr_position_clear_input) begin
         nxt_pos = `APC_POS_ZERO;                             // R07
         nxt_dev = `APC_POS_ZERO;                             // R07
      end else if (clr_rkey || pin_b_ff[`APC_PIN_HOME]) begin
         nxt_pos = `APC_POS_ZERO;                             // R06 R19
      end else if (st_ff == ST_SPEED) begin
         nxt_pos = `APC_POS_ZERO;                             // R16
      end else begin
         // Signed count in both directions
         if (step_up && !step_dn) begin
            nxt_pos = pos_ff + 1'b1;                          // R20
         end else if (step_dn && !step_up) begin
            nxt_pos = pos_ff - 1'b1;                          // R20
         end
         nxt_dev = (st_ff == ST_IDLE) ? `APC_POS_ZERO : diff;
      end
   end

   // Counter registers, origin at power-up
   always_ff @(posedge clk_in or negedge rst_b_ff) begin
      if (!rst_b_ff) begin
         pos_ff <= `APC_POS_ZERO;                             // R04
         dev_ff <= `APC_POS_ZERO;
      end else begin
         pos_ff <= nxt_pos;
         dev_ff <= nxt_dev;
      end
   end

   // Control state machine next values
   always_comb begin
      nxt_st   = st_ff;
      nxt_run  = 1'b0;
      nxt_fwd  = fwd_ff;
      nxt_lock = 1'b0;
      nxt_done = 1'b0;
      nxt_near = 1'b0;
      case (st_ff)
         ST_IDLE: begin
            if (abs_mode_in && run_req) begin
               if (spd_s) begin
                  nxt_st  = ST_SPEED;                         // R15
                  nxt_run = 1'b1;
                  nxt_fwd = fw_s;                             // R18
               end else if (target == `APC_POS_ZERO) begin
                  nxt_st   = ST_LOCK;                         // R05
                  nxt_lock = 1'b1;
                  nxt_done = 1'b1;
               end else begin
                  nxt_st  = ST_MOVE;
                  nxt_run = 1'b1;
                  nxt_fwd = (diff > 0);                       // R03
               end
            end
         end
         ST_SPEED: begin
            if (!abs_mode_in || !run_req) begin
               nxt_st = ST_IDLE;
            end else if (!spd_s) begin
               nxt_st  = ST_MOVE;                             // R17
               nxt_run = 1'b1;
            end else begin
               nxt_run = 1'b1;
               nxt_fwd = fw_s;                                // R18
            end
         end
         ST_MOVE: begin
            if (!abs_mode_in || !run_req) begin
               nxt_st = ST_IDLE;
            end else if (spd_s) begin
               nxt_st  = ST_SPEED;                            // R15
               nxt_run = 1'b1;
               nxt_fwd = fw_s;
            end else if (diff == `APC_POS_ZERO) begin
               nxt_st   = ST_LOCK;                            // R01
               nxt_lock = 1'b1;
               nxt_done = 1'b1;
            end else begin
               nxt_run  = 1'b1;                               // R01
               nxt_fwd  = (diff > 0);                         // R03
               nxt_near = ((diff < 0) ? -diff : diff) <=
                          $signed(decel_dist_in);             // R14
            end
         end
         ST_LOCK: begin
            if (!abs_mode_in || !run_req) begin
               nxt_st = ST_IDLE;                              // R01
            end else if (spd_s) begin
               nxt_st  = ST_SPEED;
               nxt_run = 1'b1;
               nxt_fwd = fw_s;
            end else begin
               // Hold the target; drift does not restart the motor, as done_ff is already set
               nxt_lock = 1'b1;                               // R01
               nxt_done = 1'b1;
               nxt_run  = (diff != `APC_POS_ZERO) && !done_ff;
               nxt_fwd  = (diff > 0);                         // R03
            end
         end
         default: begin
            nxt_st = ST_IDLE;
         end
      endcase
   end

   // Terminal functions gated by the mode
   always_comb begin
      nxt_mode.torque_en = !abs_mode_in & pin_b_ff[`APC_PIN_TRQ]; // R08
      nxt_mode.pulse_en  = !abs_mode_in & pin_b_ff[`APC_PIN_PLS]; // R09
      nxt_mode.home_en   = !abs_mode_in;                      // R10
      nxt_mode.teach_en  = abs_mode_in & pin_b_ff[`APC_PIN_TCH]; // R10
      nxt_mode.abs_ramp  = abs_mode_in;                       // R14
   end

   // Control and mode registers
   always_ff @(posedge clk_in or negedge rst_b_ff) begin
      if (!rst_b_ff) begin
         st_ff   <= ST_IDLE;
         run_ff  <= 1'b0;
         fwd_ff  <= 1'b1;
         lock_ff <= 1'b0;
         done_ff <= 1'b0;
         near_ff <= 1'b0;
         mode_ff <= '0;
      end else begin
         st_ff   <= nxt_st;
         run_ff  <= nxt_run;
         fwd_ff  <= nxt_fwd;
         lock_ff <= nxt_lock;
         done_ff <= nxt_done;
         near_ff <= nxt_near;
         mode_ff <= nxt_mode;
      end
   end

   // Outputs straight from registers, except speed_ctrl_out decoded from the state and target_pos_out from the select logic
   assign motor_run_out    = run_ff;
   assign motor_fwd_out    = fwd_ff;
   assign servo_lock_out   = lock_ff;
   assign pos_complete_out = done_ff;
   assign speed_ctrl_out   = (st_ff == ST_SPEED);
   assign near_target_out  = near_ff;
   assign current_pos_out  = pos_ff;
   assign deviation_out    = dev_ff;
   assign target_pos_out   = target;
   assign mode_out         = mode_ff;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_b_ff);

   a_dir_sign: assert property ((st_ff == ST_MOVE) && !spd_s && run_req
      && abs_mode_in && diff != 0 |=> fwd_ff == $past(diff > 0)) // R03
      else $error("Direction does not follow target sign");
   a_zero_target: assert property ((st_ff == ST_IDLE) && abs_mode_in
      && run_req && !spd_s && target == 0
      |=> done_ff && !run_ff && lock_ff)                      // R05
      else $error("Zero target did not complete at once");
   a_position_clear_input_clear: assert property (clr_position_clear_input
      |=> pos_ff == 0 && dev_ff == 0)                         // R07
      else $error("Position clear missed counter or deviation");
   a_rst_keep: assert property (rkey_s && !clr_position_clear_input
      && reset_behaviour_setting_in == `APC_RST_KEEP && st_ff != ST_SPEED
      && !pin_b_ff[`APC_PIN_HOME] && !step_up && !step_dn
      |=> pos_ff == $past(pos_ff))                            // R06
      else $error("Reset cleared counter with keep setting");
   a_speed_hold: assert property (st_ff == ST_SPEED
      |=> pos_ff == 0)                                        // R16
      else $error("Counter moved during speed control");
   a_torque_off: assert property (abs_mode_in
      |=> !mode_ff.torque_en && !mode_ff.pulse_en
         && !mode_ff.home_en)                                 // R08
      else $error("Blocked function active in absolute mode");
   a_stop_idle: assert property (!run_req
      |=> !run_ff && !lock_ff)                                // R01
      else $error("Motor still driven after run removed");
   a_home_clear: assert property (pin_b_ff[`APC_PIN_HOME] && !clr_position_clear_input
      |=> pos_ff == 0)                                        // R19
      else $error("Homing did not clear counter");
   a_spd_dir: assert property ((st_ff == ST_SPEED) && spd_s && run_req
      && abs_mode_in |=> fwd_ff == $past(fw_s))               // R18
      else $error("Speed control ignores run direction");
endmodule

// File: verification/apc_motor.sv
// Motor model: steps the position feedback while the drive runs it
`timescale 1ns/1ps
module apc_motor (
   input  wire logic       clk_in,     // System clock
   input  wire logic       run_in,     // Drive runs the motor
   input  wire logic       fwd_in,     // 1 forward, 0 reverse
   input  wire logic [7:0] period_in,  // Cycles per feedback step
   output logic            up_out,     // Forward step pulse
   output logic            down_out    // Reverse step pulse
);
   logic [7:0] cnt_ff;                 // Cycles since the last step
   // Lines rest low while the motor stands
   initial begin
      cnt_ff = 8'h00;
      up_out = 1'b0;
      down_out = 1'b0;
   end
   // One step per period while driven, prompt or slow by period_in
   always @(posedge clk_in) begin
      if (run_in && cnt_ff >= period_in - 8'h01) begin
         cnt_ff <= 8'h00;
         up_out <= fwd_in;
         down_out <= !fwd_in;
      end else begin
         cnt_ff <= run_in ? cnt_ff + 8'h01 : 8'h00;
         up_out <= 1'b0;
         down_out <= 1'b0;
      end
   end
endmodule

// File: verification/apc_top_test.sv
// Self-checking bench for the absolute position control block
`timescale 1ns/1ps
module apc_top_test;
   import apc_pkg::*;
   logic clk, rst_n, fw, rv, s0, s1, s2, son, position_clear_input, pon, rkey, speed_position_switch, home;
   logic up, dn, run, fwd, lock, done, sctl, near;
   logic amode, seen;                  // Absolute mode, near flag seen
   logic [7:0] dly, rset, per;         // Settle ms, reset code, step rate
   apc_table_t tbl;                    // Stored targets
   logic signed [31:0] cur, dev, tgt, expc;
   apc_mode_t mode;                    // Gated terminal functions
   int err_count, n_compared, prev, k;
   apc_top #(.TICKS_PER_MS(4)) uut (
      .clk_in(clk), .reset_n_in(rst_n), .abs_mode_in(amode),
      .run_forward_cmd_in(fw), .run_reverse_cmd_in(rv),
      .pos_select_bit0_in(s0), .pos_select_bit1_in(s1),
      .pos_select_bit2_in(s2), .select_assigned_in(son),
      .stored_pos_in(tbl), .select_settle_delay_in(dly),
      .position_clear_input_in(position_clear_input), .position_clear_input_assigned_in(pon),
      .reset_key_in(rkey), .reset_behaviour_setting_in(rset),
      .speed_position_switch_in(speed_position_switch), .fb_up_in(up), .fb_down_in(dn),
      .torque_control_select_in(1'b1), .pulse_train_enable_in(1'b1),
      .teach_input_in(1'b1), .homing_done_in(home),
      .decel_dist_in(32'h0000_0004), .motor_run_out(run),
      .motor_fwd_out(fwd), .servo_lock_out(lock), .pos_complete_out(done),
      .speed_ctrl_out(sctl), .near_target_out(near),
      .current_pos_out(cur), .deviation_out(dev), .target_pos_out(tgt),
      .mode_out(mode));
   apc_motor motor (.clk_in(clk), .run_in(run), .fwd_in(fwd),
      .period_in(per), .up_out(up), .down_out(dn));
   // 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Inputs change only at falling edges
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Compare one value and report a mismatch
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Bounded wait for the servo lock
   task automatic wait_lock;
      seen = 1'b0;
      for (int i = 0; i < 3000 && lock !== 1'b1; i++) begin
         tick(1);
         if (near === 1'b1) seen = 1'b1;
      end
   endtask
   // Select a target, run to it with either pin, then release the run
   task automatic move(input int idx, input logic r, input logic [7:0] p);
      logic signed [31:0] t;
      t = tbl.pos[idx];
      per = p;
      {s2, s1, s0} = idx[2:0];
      tick(5);
      chk("early target", tbl.pos[prev], tgt);
      tick(12);
      chk("target", t, tgt);
      prev = idx;
      rv = r;
      fw = !r;
      tick(4);
      chk("run", 1'b1, run);
      chk("direction", 32'(t > expc), fwd);
      chk("far", 32'h0, near);
      wait_lock();
      chk("near seen", 1'b1, seen);
      chk("position", t, cur);
      chk("complete", 1'b1, done);
      chk("deviation", 32'h0, dev);
      fw = 1'b0;
      rv = 1'b0;
      tick(4);
      chk("lock after stop", 1'b0, lock);
      expc = t;
   endtask
   // Print the counts and the verdict, then stop
   task automatic give_verdict;
      $display("Compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Watchdog against a hang
   initial begin
      #(25 * 60000);
      err_count++;
      give_verdict();
   end
   // Main sequence
   initial begin
      {rst_n, fw, rv, position_clear_input, pon, rkey, speed_position_switch, home} = 8'h00;
      amode = 1'b0;
      {s2, s1, s0} = 3'b111;
      son = 1'b0;
      dly = 8'h02;
      rset = 8'h00;
      per = 8'h06;
      err_count = 0;
      n_compared = 0;
      prev = 0;
      expc = 32'h0;
      tbl.pos[0] = 32'h0;
      for (int i = 1; i < 8; i++) begin
         tbl.pos[i] = i[0] ? 32'(i * 7) : -32'(i * 5);
      end
      tick(12);
      rst_n = 1'b1;
      tick(6);
      chk("origin", 32'h0, cur);
      chk("mode off", 32'h1c, mode);
      amode = 1'b1;
      tick(2);
      chk("mode", 32'h3, mode);
      tick(9);
      chk("unassigned", tbl.pos[0], tgt);
      fw = 1'b1;
      tick(6);
      chk("zero run", 1'b0, run);
      chk("zero complete", 1'b1, done);
      fw = 1'b0;
      {s2, s1, s0} = 3'b000;
      tick(17);
      son = 1'b1;
      for (int i = 1; i < 8; i++) move(i, i[1], 8'd6 + 8'(i[0] * 4));
      // Clears: key kept, unassigned clear, homing, clear, key
      for (k = 0; k < 5; k++) begin
         move(k + 1, k[0], 8'd6 + 8'(k));
         rset = (k == 0) ? 8'h03 : 8'h00;
         pon = (k == 3);
         rkey = (k == 0 || k == 4);
         position_clear_input = (k == 1 || k == 3);
         home = (k == 2);
         tick(5);
         expc = (k < 2) ? tbl.pos[k + 1] : 32'h0;
         chk("cleared", expc, cur);
         {rkey, position_clear_input, home} = 3'b000;
         tick(4);
      end
      // Speed control with the reverse pin, then forward
      son = 1'b0;
      per = 8'd10;
      speed_position_switch = 1'b1;
      rv = 1'b1;
      tick(6);
      chk("speed mode", 1'b1, sctl);
      chk("speed run", 1'b1, run);
      chk("speed dir", 1'b0, fwd);
      repeat (3) begin
         tick(10);
         chk("held", 32'h0, cur);
      end
      rv = 1'b0;
      fw = 1'b1;
      tick(5);
      chk("speed dir fwd", 1'b1, fwd);
      @(posedge up);
      tick(4);
      speed_position_switch = 1'b0;
      tick(8);
      chk("switch run", 1'b0, run);
      chk("switch lock", 1'b1, lock);
      fw = 1'b0;
      tick(4);
      give_verdict();
   end
endmodule
